// file: logic/lmsa_pkg.sv
// lmsa_pkg: register map, field layout and mode codes of the lcd
// mode selector and segment allocation block
// assumes word-per-register AXI4-Lite access, byte address = 4 * index
`default_nettype none
package lmsa_pkg;
   // bus geometry
   localparam int AXI_AW   = 18;
   localparam int AXI_DW   = 32;
   localparam int IDX_W    = 16;
   localparam int IDX_LSB  = 2;
   // register indices (byte address is four times these)
   localparam logic [15:0] IDX_DMR1      = 16'hf0f3;
   localparam logic [15:0] IDX_MODE_CTRL = 16'hf0f4;
   localparam logic [15:0] IDX_ADDR_TAB  = 16'hf400;
   localparam logic [15:0] IDX_BIT_TAB   = 16'hf600;
   // allocation table geometry
   localparam int TAB_AW    = 9;
   localparam int SEG_COUNT = 64;
   localparam int COM_COUNT = 8;
   localparam int PIX_COUNT = SEG_COUNT * COM_COUNT;
   localparam int DD_BITS   = 2048;
   localparam int BITSEL_W  = 3;
   // field positions
   localparam int ALLOC_EN_BIT = 2;
   localparam int MODE_LSB     = 0;
   localparam int MODE_W       = 2;
   // reset values
   localparam logic [7:0] MODE_CTRL_RST = 8'h00;
   localparam logic [7:0] DMR1_RST      = 8'h00;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      DRV_STOP    = 2'h0,
      DRV_ALL_OFF = 2'h1,
      DRV_NORMAL  = 2'h2,
      DRV_ALL_ON  = 2'h3
   } lmsa_drive_mode_t;

   typedef enum logic [2:0]
   {
      REG_NONE = 3'h0,
      REG_MODE = 3'h1,
      REG_DMR1 = 3'h2,
      REG_ATAB = 3'h3,
      REG_BTAB = 3'h4
   } lmsa_region_t;
endpackage
`default_nettype wire

// file: logic/lmsa_top.sv
// lmsa_top: drive mode selector and programmable segment allocation
// assumes display data and fixed-map pixels come from same-clock logic
// Contract
// [RL1] allocation enable 0 at reset means allocation off, 1 means on
// [RL2] software should pick segment map type 3 when allocation is on
// [RL3] two-bit drive mode: 00 stop, 01 all-off, 10 normal, 11 all-on
// [RL4] stop mode grounds every common and segment output
// [RL5] all-off mode gives every segment the off waveform
// [RL6] normal mode gives each segment what its display bit asks for
// [RL7] all-on mode gives every segment the on waveform
// [RL8] one allocation entry per pair: segments 0..63, commons 0..7
// [RL9] address entry is the low byte of the source display register
// [RL10] address table entry for common n, segment m at base+64n+m
// [RL11] bit table, same order, low three bits pick source bit 0..7
// [RL12] both tables hold no reset value
// [RL13] tables act as plain 512-byte memories while allocation is off
// [RL14] software writes tables only while allocation enable is 0
// [RL15] table accesses are ignored while allocation is enabled
// [RL16] mode control register holds 00h after reset
// [RL17] allocation enable is bit 2 of display mode register one
// [RL18] display bit 0 selects off waveform, 1 selects on waveform
// [RL19] allocated pixel is chosen bit of the addressed data register
`timescale 1ns/1ps
`default_nettype none
module lmsa_top
(
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // axi4-lite write address and data
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [lmsa_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   input  wire logic [lmsa_pkg::AXI_DW-1:0]   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   // axi4-lite write response
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   output logic [1:0]                         s_axi_bresp,
   // axi4-lite read
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   input  wire logic [lmsa_pkg::AXI_AW-1:0]   s_axi_araddr,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [lmsa_pkg::AXI_DW-1:0]        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   // display data and fixed-map pixels
   input  wire logic [lmsa_pkg::DD_BITS-1:0]  display_data,
   input  wire logic [lmsa_pkg::PIX_COUNT-1:0] map_pixel,
   // panel side
   output logic [lmsa_pkg::PIX_COUNT-1:0]     segment_output_on,
   output logic                               lcd_drive_on
);
   typedef struct packed
   {
      logic [7:0]                        mode_ctrl;
      logic [7:0]                        dmr1;
      logic                              aw_held;
      logic [lmsa_pkg::IDX_W-1:0]        aw_idx;
      logic                              w_held;
      logic [7:0]                        w_data;
      logic                              w_lane0;
      logic                              bvalid;
      logic [1:0]                        bresp;
      logic                              rvalid;
      logic [1:0]                        rresp;
      logic [7:0]                        rdata;
      logic [lmsa_pkg::TAB_AW-1:0]       scan_idx;
      logic [lmsa_pkg::PIX_COUNT-1:0]    alloc_pix;
      logic [lmsa_pkg::PIX_COUNT-1:0]    seg_pix;
      logic                              drive_on;
   } lmsa_state_t;

   localparam lmsa_state_t ST_RST = '{
      mode_ctrl: lmsa_pkg::MODE_CTRL_RST,
      dmr1:      lmsa_pkg::DMR1_RST,
      default:   '0
   };

   lmsa_state_t                    q;
   lmsa_state_t                    d;
   logic [7:0]                     tab_a [lmsa_pkg::PIX_COUNT];
   logic [7:0]                     tab_b [lmsa_pkg::PIX_COUNT];
   logic                           alloc_en;
   logic                           aw_go;
   logic                           w_go;
   logic                           wr_go;
   logic                           ar_go;
   lmsa_pkg::lmsa_region_t         wr_reg;
   lmsa_pkg::lmsa_region_t         ar_reg;
   logic [lmsa_pkg::TAB_AW-1:0]    wr_off;
   logic [lmsa_pkg::TAB_AW-1:0]    ar_off;
   logic [lmsa_pkg::IDX_W-1:0]     ar_idx;
   logic [7:0]                     rd_val;
   logic                           scan_bit;
   logic                           tab_a_we;
   logic                           tab_b_we;
   lmsa_pkg::lmsa_drive_mode_t     mode;

   // register index to region
   function automatic lmsa_pkg::lmsa_region_t region_of
   (
      input logic [lmsa_pkg::IDX_W-1:0] idx
   );
      lmsa_pkg::lmsa_region_t r;
      r = lmsa_pkg::REG_NONE;
      if (idx == lmsa_pkg::IDX_MODE_CTRL)
      begin
         r = lmsa_pkg::REG_MODE;
      end
      else if (idx == lmsa_pkg::IDX_DMR1)
      begin
         r = lmsa_pkg::REG_DMR1;
      end
      else if (idx[lmsa_pkg::IDX_W-1:lmsa_pkg::TAB_AW] ==
               lmsa_pkg::IDX_ADDR_TAB[lmsa_pkg::IDX_W-1:lmsa_pkg::TAB_AW])
      begin
         r = lmsa_pkg::REG_ATAB;
      end
      else if (idx[lmsa_pkg::IDX_W-1:lmsa_pkg::TAB_AW] ==
               lmsa_pkg::IDX_BIT_TAB[lmsa_pkg::IDX_W-1:lmsa_pkg::TAB_AW])
      begin
         r = lmsa_pkg::REG_BTAB;
      end
      return r;
   endfunction

   // entry offset inside a table: 64 * common + segment
   function automatic logic [lmsa_pkg::TAB_AW-1:0] tab_off
   (
      input logic [lmsa_pkg::IDX_W-1:0] idx
   );
      return idx[lmsa_pkg::TAB_AW-1:0]; // RL10 RL11
   endfunction

   assign alloc_en = q.dmr1[lmsa_pkg::ALLOC_EN_BIT]; // RL1 RL17
   assign mode = lmsa_pkg::lmsa_drive_mode_t'(
      q.mode_ctrl[lmsa_pkg::MODE_LSB +: lmsa_pkg::MODE_W]); // RL3

   // bus handshakes
   assign s_axi_awready = !q.aw_held && !q.bvalid;
   assign s_axi_wready  = !q.w_held && !q.bvalid;
   assign s_axi_arready = !q.rvalid;
   assign aw_go = s_axi_awvalid && s_axi_awready;
   assign w_go  = s_axi_wvalid && s_axi_wready;
   assign ar_go = s_axi_arvalid && s_axi_arready;
   assign wr_go = q.aw_held && q.w_held && !q.bvalid;
   assign wr_reg = region_of(q.aw_idx);
   assign wr_off = tab_off(q.aw_idx);
   assign ar_idx = s_axi_araddr[lmsa_pkg::AXI_AW-1:lmsa_pkg::IDX_LSB];
   assign ar_reg = region_of(ar_idx);
   assign ar_off = tab_off(ar_idx);

   // table writes refused while allocation runs
   assign tab_a_we = wr_go && q.w_lane0 && !alloc_en &&
                     wr_reg == lmsa_pkg::REG_ATAB; // RL13 RL15
   assign tab_b_we = wr_go && q.w_lane0 && !alloc_en &&
                     wr_reg == lmsa_pkg::REG_BTAB; // RL13 RL15

   // read data mux
   always_comb
   begin
      rd_val = 8'h00;
      if (ar_reg == lmsa_pkg::REG_MODE)
      begin
         rd_val = q.mode_ctrl;
      end
      else if (ar_reg == lmsa_pkg::REG_DMR1)
      begin
         rd_val = q.dmr1;
      end
      else if (ar_reg == lmsa_pkg::REG_ATAB && !alloc_en)
      begin
         rd_val = tab_a[ar_off]; // RL13 RL15
      end
      else if (ar_reg == lmsa_pkg::REG_BTAB && !alloc_en)
      begin
         rd_val = tab_b[ar_off]; // RL13 RL15
      end
   end

   // source bit of the pair under scan
   assign scan_bit = display_data[{tab_a[q.scan_idx],
      tab_b[q.scan_idx][lmsa_pkg::BITSEL_W-1:0]}]; // RL9 RL11 RL19

   always_comb
   begin
      d = q;
      if (aw_go)
      begin
         d.aw_held = 1'b1;
         d.aw_idx  = s_axi_awaddr[lmsa_pkg::AXI_AW-1:lmsa_pkg::IDX_LSB];
      end
      if (w_go)
      begin
         d.w_held  = 1'b1;
         d.w_data  = s_axi_wdata[7:0];
         d.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_go)
      begin
         d.aw_held = 1'b0;
         d.w_held  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = (wr_reg == lmsa_pkg::REG_NONE) ?
                     lmsa_pkg::RESP_SLVERR : lmsa_pkg::RESP_OKAY;
         if (q.w_lane0 && wr_reg == lmsa_pkg::REG_MODE)
         begin
            d.mode_ctrl = q.w_data; // RL3
         end
         if (q.w_lane0 && wr_reg == lmsa_pkg::REG_DMR1)
         begin
            d.dmr1 = q.w_data; // RL17
         end
      end
      else if (q.bvalid && s_axi_bready)
      begin
         d.bvalid = 1'b0;
      end
      if (ar_go)
      begin
         d.rvalid = 1'b1;
         d.rdata  = rd_val;
         d.rresp  = (ar_reg == lmsa_pkg::REG_NONE) ?
                    lmsa_pkg::RESP_SLVERR : lmsa_pkg::RESP_OKAY;
      end
      else if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
      end
      // one pair per cycle while allocation is on
      if (alloc_en)
      begin
         d.scan_idx = q.scan_idx + 1'b1;
         d.alloc_pix[q.scan_idx] = scan_bit; // RL8 RL19
      end
      else
      begin
         d.scan_idx = '0;
      end
      // output stage, bit 1 means on waveform
      d.drive_on = (mode != lmsa_pkg::DRV_STOP); // RL4
      case (mode)
         lmsa_pkg::DRV_STOP:    d.seg_pix = '0; // RL4
         lmsa_pkg::DRV_ALL_OFF: d.seg_pix = '0; // RL5
         lmsa_pkg::DRV_ALL_ON:  d.seg_pix = '1; // RL7
         default:
         begin
            d.seg_pix = alloc_en ? q.alloc_pix : map_pixel; // RL6 RL18
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= ST_RST; // RL1 RL16
      end
      else
      begin
         q <= d;
      end
   end

   // allocation tables, no reset
   always_ff @(posedge clk)
   begin
      if (tab_a_we)
      begin
         tab_a[wr_off] <= q.w_data; // RL12
      end
      if (tab_b_we)
      begin
         tab_b[wr_off] <= q.w_data; // RL12
      end
   end

   assign s_axi_bvalid      = q.bvalid;
   assign s_axi_bresp       = q.bresp;
   assign s_axi_rvalid      = q.rvalid;
   assign s_axi_rresp       = q.rresp;
   assign s_axi_rdata       = {24'h000000, q.rdata};
   assign segment_output_on = q.seg_pix;
   assign lcd_drive_on      = q.drive_on;

   a_mode_after_reset: assert property ( // RL16
      @(posedge clk) $fell(rst) |-> q.mode_ctrl == lmsa_pkg::MODE_CTRL_RST
         && !lcd_drive_on)
      else $error("mode control not cleared by reset");

   a_stop_grounds: assert property ( // RL4
      @(posedge clk) disable iff (rst)
      mode == lmsa_pkg::DRV_STOP |=> !lcd_drive_on && segment_output_on == '0)
      else $error("stop mode drives panel");

   a_all_off: assert property ( // RL5
      @(posedge clk) disable iff (rst)
      mode == lmsa_pkg::DRV_ALL_OFF |=> lcd_drive_on
         && segment_output_on == '0)
      else $error("all-off mode shows a lit segment");

   a_all_on: assert property ( // RL7
      @(posedge clk) disable iff (rst)
      mode == lmsa_pkg::DRV_ALL_ON |=> lcd_drive_on && &segment_output_on)
      else $error("all-on mode shows a dark segment");

   a_normal_direct: assert property ( // RL6
      @(posedge clk) disable iff (rst)
      mode == lmsa_pkg::DRV_NORMAL && !alloc_en
         |=> segment_output_on == $past(map_pixel))
      else $error("normal mode lost display data");

   a_normal_alloc: assert property ( // RL19
      @(posedge clk) disable iff (rst)
      mode == lmsa_pkg::DRV_NORMAL && alloc_en
         |=> segment_output_on == $past(q.alloc_pix))
      else $error("normal mode ignores allocation");

   a_scan_fetch: assert property ( // RL9
      @(posedge clk) disable iff (rst)
      alloc_en |=> q.alloc_pix[$past(q.scan_idx)] == $past(scan_bit)
         && q.scan_idx == $past(q.scan_idx) + 1'b1)
      else $error("allocated pixel not fetched");

   a_table_locked: assert property ( // RL15
      @(posedge clk) disable iff (rst)
      ar_go && alloc_en && (ar_reg == lmsa_pkg::REG_ATAB
         || ar_reg == lmsa_pkg::REG_BTAB)
         |=> s_axi_rvalid && s_axi_rdata == '0)
      else $error("table read while allocation enabled");

   a_enable_write: assert property ( // RL17
      @(posedge clk) disable iff (rst)
      wr_go && q.w_lane0 && wr_reg == lmsa_pkg::REG_DMR1
         |=> alloc_en == $past(q.w_data[lmsa_pkg::ALLOC_EN_BIT])
         && s_axi_bvalid)
      else $error("allocation enable not written");
endmodule
`default_nettype wire

// file: bench/lmsa_panel.sv
// lmsa_panel: behavioural lcd panel at the far side of the block
// assumes electrodes are seen through the per-pair on flags and drive
`timescale 1ns/1ps
`default_nettype none
module lmsa_panel
(
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   // electrodes
   input  wire logic [lmsa_pkg::PIX_COUNT-1:0]  seg_on,
   input  wire logic                            drive_on,
   // what the glass shows
   output logic                                 grounded,
   output logic                                 any_lit
);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         grounded <= 1'b1;
         any_lit  <= 1'b0;
      end
      else
      begin
         grounded <= !drive_on;
         any_lit  <= drive_on && (|seg_on);
      end
   end
endmodule
`default_nettype wire

// file: bench/lcd_mode_and_segment_allocation_test.sv
// lcd_mode_and_segment_allocation_test: register and mode scenarios
// assumes the block and panel model share one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module lcd_mode_and_segment_allocation_test;
   localparam logic [1:0] OK = lmsa_pkg::RESP_OKAY;
   localparam logic [1:0] ER = lmsa_pkg::RESP_SLVERR;
   logic          clk, rst, grounded, any_lit;
   logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic          s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic          s_axi_rready, lcd_drive_on;
   logic [17:0]   s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [2047:0] display_data;
   logic [511:0]  map_pixel, segment_output_on, exp_seg;
   int            fail_count, comparisons;
   int            pix [3] = '{0, 65, 511};
   logic [7:0]    src [3] = '{8'h00, 8'h3f, 8'hfe};
   logic [7:0]    bsel [3] = '{8'hf8, 8'hfd, 8'hff};
   logic          expv [3] = '{1'b1, 1'b1, 1'b0};

   lmsa_top dut_u
   (
      .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .display_data, .map_pixel,
      .segment_output_on, .lcd_drive_on
   );
   lmsa_panel panel_u
   (
      .clk, .rst, .seg_on(segment_output_on), .drive_on(lcd_drive_on),
      .grounded, .any_lit
   );

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string nm, input logic [511:0] seen,
                        input logic [511:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hang();
      fail_count++;
      $display("BAD handshake expected answer seen none");
      print_verdict();
   endtask

   // write one byte, release each channel once taken
   task automatic wchk(input logic [15:0] idx, input logic [7:0] d,
                       input logic [1:0] er);
      logic aw_hit, w_hit, b_hit;
      logic [1:0] resp;
      int n;
      @(posedge clk);
      s_axi_awaddr  <= {idx, 2'h0};
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(negedge clk);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit  = s_axi_wvalid && s_axi_wready;
         b_hit  = s_axi_bvalid && s_axi_bready;
         resp   = s_axi_bresp;
         @(posedge clk);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
         if (b_hit)
         begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (n == 50) hang();
      check("bresp", 512'(resp), 512'(er));
   endtask

   task automatic rchk(input logic [15:0] idx, input logic [7:0] ed,
                       input logic [1:0] er);
      logic ar_hit, r_hit;
      logic [31:0] data;
      logic [1:0] resp;
      int n;
      @(posedge clk);
      s_axi_araddr  <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(negedge clk);
         ar_hit = s_axi_arvalid && s_axi_arready;
         r_hit  = s_axi_rvalid && s_axi_rready;
         data   = s_axi_rdata;
         resp   = s_axi_rresp;
         @(posedge clk);
         if (ar_hit) s_axi_arvalid <= 1'b0;
         if (r_hit)
         begin
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (n == 50) hang();
      check("rdata", 512'(data), 512'(ed));
      check("rresp", 512'(resp), 512'(er));
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h1;
      map_pixel = {64{8'h5a}};
      display_data = '0;
      display_data[0] = 1'b1;
      display_data[8] = 1'b1;
      display_data[509] = 1'b1;
      display_data[2038] = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      settle(1);
      check("reset drive", 512'(lcd_drive_on), 512'h0);
      rchk(lmsa_pkg::IDX_MODE_CTRL, 8'h00, OK);
      rchk(lmsa_pkg::IDX_DMR1, 8'h00, OK);
      rchk(16'h0100, 8'h00, ER);
      wchk(16'h0100, 8'h55, ER);
      // tables start unknown: give every pair byte 1, bit 0
      for (int i = 0; i < lmsa_pkg::PIX_COUNT; i++)
      begin
         wchk(lmsa_pkg::IDX_ADDR_TAB + 16'(i), 8'h01, OK);
         wchk(lmsa_pkg::IDX_BIT_TAB + 16'(i), 8'h00, OK);
      end
      for (int i = 0; i < 3; i++)
      begin
         wchk(lmsa_pkg::IDX_ADDR_TAB + 16'(pix[i]), src[i], OK);
         wchk(lmsa_pkg::IDX_BIT_TAB + 16'(pix[i]), bsel[i], OK);
         rchk(lmsa_pkg::IDX_ADDR_TAB + 16'(pix[i]), src[i], OK);
         rchk(lmsa_pkg::IDX_BIT_TAB + 16'(pix[i]), bsel[i], OK);
      end
      for (int m = 0; m < 4; m++)
      begin
         wchk(lmsa_pkg::IDX_MODE_CTRL, 8'(m), OK);
         settle(3);
         exp_seg = (m == 2) ? map_pixel : ((m == 3) ? '1 : '0);
         check("segments", segment_output_on, exp_seg);
         check("drive", 512'(lcd_drive_on), 512'(m != 0));
         check("grounded", 512'(grounded), 512'(m == 0));
         check("lit", 512'(any_lit), 512'(m >= 2));
      end
      wchk(lmsa_pkg::IDX_MODE_CTRL, 8'h02, OK);
      map_pixel <= '0;
      wchk(lmsa_pkg::IDX_DMR1, 8'h06, OK);
      settle(1100);
      for (int i = 0; i < 3; i++)
         check("alloc", 512'(segment_output_on[pix[i]]),
               512'(expv[i]));
      check("alloc fill", 512'(segment_output_on[300]), 512'h1);
      @(posedge clk);
      display_data[0] <= 1'b0;
      settle(1100);
      check("alloc off", 512'(segment_output_on[0]), 512'h0);
      rchk(lmsa_pkg::IDX_ADDR_TAB + 16'd65, 8'h00, OK);
      wchk(lmsa_pkg::IDX_ADDR_TAB, 8'h11, OK);
      wchk(lmsa_pkg::IDX_BIT_TAB, 8'h11, OK);
      wchk(lmsa_pkg::IDX_DMR1, 8'h02, OK);
      rchk(lmsa_pkg::IDX_DMR1, 8'h02, OK);
      rchk(lmsa_pkg::IDX_ADDR_TAB, 8'h00, OK);
      rchk(lmsa_pkg::IDX_BIT_TAB, 8'hf8, OK);
      print_verdict();
   end
endmodule
`default_nettype wire
